// ### design/eis_bank.sv
// Ethernet event flags, buffer counter, busy status and frame statistics behind APB
// How it works
// - Pending flag follows counter nonzero; writes to it do nothing
// - Receive-activity flag sets when packet data enters receive FIFO
// - Transmit-done flag sets when a packet finishes with status written
// - Transmit-abort flag sets on any of five MAC abort causes
// - Buffer-unavailable flag sets on descriptor overrun
// - Overflow flag sets when the receive FIFO overflows
// - Event flags clear on reset, a one written to clear or invert alias, or a zero in a plain write
// - 8-bit counter in status bits 23:16 adds descriptors per packet
// - Counter saturates at 0xFF and at zero, never wraps
// - Simultaneous decrement and increment leave counter unchanged
// - At 0xFF with flow control on, receive halts until decrement
// - Writing descriptor start address clears the counter
// - Counter survives module disable and stays decrementable
// - Module busy while on, and until pending transaction ends after off
// - Transmit busy while sending, forced low when module off
// - Receive busy while receiving, forced low when module off
// - Dropped-frame counter counts filtered frames lost to FIFO overrun
// - Statistics clear after read unless byte enables 0 and 1 both low
// - Transmitted-frame counter counts each good frame
// - Pending interrupt requested only when its enable bit is set
`timescale 1ns/10ps
`default_nettype none
`include "eis_defs.svh"

module eis_bank (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire eis_pkg::eis_events_t ev,
  output logic                    rx_halt,
  output logic                    module_on,
  output logic                    packet_pending_irq
);

  eis_pkg::eis_state_t s_q;
  eis_pkg::eis_state_t s_d;

  // Read byte enables: APB reads carry no strobe, yet pstrb is honoured on reads only; writes ignore it
  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    sat_add = t[8] ? `EIS_CNT_MAX : t[7:0];
  endfunction : sat_add

  function automatic logic [15:0] inc16(input logic [15:0] a);
    inc16 = a + 16'h0001;
  endfunction : inc16

  logic        acc;
  logic        wr;
  logic        rd;
  logic [11:0] reg_off;
  logic [3:0]  alias_sel;
  logic [7:0]  new_ev;
  logic [7:0]  wr_flags;
  logic        dec;
  logic        hw_inc;
  logic        mapped;
  logic        rd_clear;
  logic [7:0]  cnt_after;

  always_comb begin
    acc       = psel & penable;
    wr        = acc & pwrite;
    rd        = acc & ~pwrite;
    reg_off   = {paddr[11:4], 4'h0};
    alias_sel = paddr[3:0];
    mapped    = (alias_sel[1:0] == 2'b00) &&
                (reg_off == `EIS_OFF_IRQ  || reg_off == `EIS_OFF_STAT ||
                 reg_off == `EIS_OFF_DROP || reg_off == `EIS_OFF_TXOK ||
                 reg_off == `EIS_OFF_CTRL || reg_off == `EIS_OFF_IEN  ||
                 reg_off == `EIS_OFF_RXST);
    rd_clear  = rd & (pstrb[0] | pstrb[1]);
    new_ev    = 8'h00;
    new_ev[`EIS_BIT_RECEIVE_ACTIVITY_FLAG]   = ev.rx_data_stored;
    new_ev[`EIS_BIT_TRANSMIT_DONE_FLAG]  = ev.tx_done;
    new_ev[`EIS_BIT_TRANSMIT_ABORT_FLAG] = ev.tx_abort;
    new_ev[`EIS_BIT_BUFNA]   = ev.rx_desc_overrun;
    new_ev[`EIS_BIT_OVFL]    = ev.rx_fifo_overflow | ev.rx_dropped_frame;
    dec       = wr && mapped && reg_off == `EIS_OFF_CTRL && alias_sel != `EIS_ALIAS_CLR &&
                pwdata[`EIS_CTRL_DEC];
    hw_inc    = ev.rx_packet_ok && ev.rx_desc_used != 8'h00;
    cnt_after = s_q.buf_count;

    s_d = s_q;
    s_d.rdata = 32'h0000_0000;

    // Flags: software write first, then hardware set on top so an event is never lost
    wr_flags = s_q.flags;
    if (wr && mapped && reg_off == `EIS_OFF_IRQ) begin
      if (alias_sel == `EIS_ALIAS_CLR) begin
        wr_flags = s_q.flags & ~pwdata[7:0];
      end else if (alias_sel == `EIS_ALIAS_SET) begin
        wr_flags = s_q.flags | pwdata[7:0];
      end else if (alias_sel == `EIS_ALIAS_INV) begin
        wr_flags = s_q.flags ^ pwdata[7:0];
      end else begin
        wr_flags = pwdata[7:0];
      end
    end
    s_d.flags = (wr_flags | new_ev) & `EIS_FLAG_MASK;

    // Buffer counter
    if (hw_inc && dec) begin
      cnt_after = s_q.buf_count;
    end else if (hw_inc) begin
      cnt_after = sat_add(s_q.buf_count, ev.rx_desc_used);
    end else if (dec && s_q.buf_count != `EIS_RST_CNT) begin
      cnt_after = s_q.buf_count - 8'h01;
    end
    if (wr && mapped && reg_off == `EIS_OFF_RXST) begin
      cnt_after = `EIS_RST_CNT;
    end
    s_d.buf_count = cnt_after;

    // Control and enable registers, plain or through aliases
    if (wr && mapped && reg_off == `EIS_OFF_CTRL) begin
      if (alias_sel == `EIS_ALIAS_CLR) begin
        s_d.module_on = s_q.module_on & ~pwdata[`EIS_CTRL_ON];
        s_d.auto_flow = s_q.auto_flow & ~pwdata[`EIS_CTRL_AFC];
      end else if (alias_sel == `EIS_ALIAS_SET) begin
        s_d.module_on = s_q.module_on | pwdata[`EIS_CTRL_ON];
        s_d.auto_flow = s_q.auto_flow | pwdata[`EIS_CTRL_AFC];
      end else if (alias_sel == `EIS_ALIAS_INV) begin
        s_d.module_on = s_q.module_on ^ pwdata[`EIS_CTRL_ON];
        s_d.auto_flow = s_q.auto_flow ^ pwdata[`EIS_CTRL_AFC];
      end else begin
        s_d.module_on = pwdata[`EIS_CTRL_ON];
        s_d.auto_flow = pwdata[`EIS_CTRL_AFC];
      end
    end
    if (wr && mapped && reg_off == `EIS_OFF_IEN) begin
      if (alias_sel == `EIS_ALIAS_CLR) begin
        s_d.pend_irq_en = s_q.pend_irq_en & ~pwdata[`EIS_BIT_PEND];
      end else if (alias_sel == `EIS_ALIAS_SET) begin
        s_d.pend_irq_en = s_q.pend_irq_en | pwdata[`EIS_BIT_PEND];
      end else if (alias_sel == `EIS_ALIAS_INV) begin
        s_d.pend_irq_en = s_q.pend_irq_en ^ pwdata[`EIS_BIT_PEND];
      end else begin
        s_d.pend_irq_en = pwdata[`EIS_BIT_PEND];
      end
    end

    // Busy tail holds module busy after disable until the transaction drains
    s_d.busy_tail = (s_q.module_on | s_q.busy_tail) & ev.txn_pending;

    // Statistics: a clearing read that meets an event keeps that event as the new count
    if (rd_clear && mapped && reg_off == `EIS_OFF_DROP) begin
      s_d.dropped_frames = ev.rx_dropped_frame ? 16'h0001 : `EIS_RST_STAT16;
    end else if (ev.rx_dropped_frame) begin
      s_d.dropped_frames = inc16(s_q.dropped_frames);
    end
    if (rd_clear && mapped && reg_off == `EIS_OFF_TXOK) begin
      s_d.tx_frames = ev.tx_frame_ok ? 16'h0001 : `EIS_RST_STAT16;
    end else if (ev.tx_frame_ok) begin
      s_d.tx_frames = inc16(s_q.tx_frames);
    end

    // Read data is captured in the setup cycle so the access phase answers at once
    if (psel && !penable && !pwrite) begin
      if (reg_off == `EIS_OFF_IRQ) begin
        s_d.rdata[7:0] = s_q.flags | {1'b0, s_q.buf_count != 8'h00, 6'h00};
      end else if (reg_off == `EIS_OFF_STAT) begin
        s_d.rdata[23:16] = s_q.buf_count;
        s_d.rdata[`EIS_BIT_MODBUSY] = s_q.module_on | s_q.busy_tail;
        s_d.rdata[`EIS_BIT_TRANSMIT_BUSY_STATUS]  = s_q.module_on & ev.tx_active;
        s_d.rdata[`EIS_BIT_RECEIVE_BUSY_STATUS]  = s_q.module_on & ev.rx_active;
      end else if (reg_off == `EIS_OFF_DROP) begin
        s_d.rdata[15:0] = s_q.dropped_frames;
      end else if (reg_off == `EIS_OFF_TXOK) begin
        s_d.rdata[15:0] = s_q.tx_frames;
      end else if (reg_off == `EIS_OFF_CTRL) begin
        s_d.rdata[`EIS_CTRL_ON]  = s_q.module_on;
        s_d.rdata[`EIS_CTRL_AFC] = s_q.auto_flow;
      end else if (reg_off == `EIS_OFF_IEN) begin
        s_d.rdata[`EIS_BIT_PEND] = s_q.pend_irq_en;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    s_d.bus = acc ? eis_pkg::EIS_ACCESS : eis_pkg::EIS_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q <= '{bus: eis_pkg::EIS_IDLE, flags: `EIS_RST_FLAGS, buf_count: `EIS_RST_CNT,
               dropped_frames: `EIS_RST_STAT16, tx_frames: `EIS_RST_STAT16,
               module_on: 1'b0, auto_flow: 1'b0, pend_irq_en: 1'b0, busy_tail: 1'b0,
               rdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; read data was latched during setup
  always_comb begin
    pready             = 1'b1;
    pslverr            = psel & penable & ~mapped;
    prdata             = s_q.rdata;
    module_on          = s_q.module_on;
    rx_halt            = s_q.auto_flow && s_q.buf_count == `EIS_CNT_MAX;
    packet_pending_irq = s_q.pend_irq_en && s_q.buf_count != 8'h00;
  end

endmodule : eis_bank
`default_nettype wire

// ### common/eis_defs.svh
// Register offsets, field positions, reset values and alias offsets for the event/status bank
`ifndef EIS_DEFS_SVH
`define EIS_DEFS_SVH
`define EIS_ALIAS_BASE      4'h0
`define EIS_ALIAS_CLR       4'h4
`define EIS_ALIAS_SET       4'h8
`define EIS_ALIAS_INV       4'hc
`define EIS_OFF_IRQ         12'h000
`define EIS_OFF_STAT        12'h010
`define EIS_OFF_DROP        12'h020
`define EIS_OFF_TXOK        12'h030
`define EIS_OFF_CTRL        12'h040
`define EIS_OFF_IEN         12'h050
`define EIS_OFF_RXST        12'h060
`define EIS_BIT_PEND        6
`define EIS_BIT_RECEIVE_ACTIVITY_FLAG       5
`define EIS_BIT_TRANSMIT_DONE_FLAG      3
`define EIS_BIT_TRANSMIT_ABORT_FLAG     2
`define EIS_BIT_BUFNA       1
`define EIS_BIT_OVFL        0
`define EIS_BIT_MODBUSY     7
`define EIS_BIT_TRANSMIT_BUSY_STATUS      6
`define EIS_BIT_RECEIVE_BUSY_STATUS      5
`define EIS_CNT_LSB         16
`define EIS_CTRL_ON         15
`define EIS_CTRL_AFC        1
`define EIS_CTRL_DEC        0
`define EIS_FLAG_MASK       8'h2f
`define EIS_CNT_MAX         8'hff
`define EIS_RST_FLAGS       8'h00
`define EIS_RST_CNT         8'h00
`define EIS_RST_STAT16      16'h0000
`endif

// ### common/eis_pkg.sv
// Types shared by the event/status bank
package eis_pkg;
  typedef struct packed {
    logic       rx_data_stored;
    logic       tx_done;
    logic       tx_abort;
    logic       rx_desc_overrun;
    logic       rx_fifo_overflow;
    logic       rx_packet_ok;
    logic [7:0] rx_desc_used;
    logic       tx_frame_ok;
    logic       rx_dropped_frame;
    logic       rx_active;
    logic       tx_active;
    logic       txn_pending;
  } eis_events_t;

  typedef enum logic [1:0] {
    EIS_IDLE    = 2'b00,
    EIS_ACCESS  = 2'b01
  } eis_bus_t;

  typedef struct packed {
    eis_bus_t    bus;
    logic [7:0]  flags;
    logic [7:0]  buf_count;
    logic [15:0] dropped_frames;
    logic [15:0] tx_frames;
    logic        module_on;
    logic        auto_flow;
    logic        pend_irq_en;
    logic        busy_tail;
    logic [31:0] rdata;
  } eis_state_t;
endpackage : eis_pkg

// ### testbench/eis_bank_monitor.sv
// Port-level assertions for the event/status bank
`timescale 1ns/10ps
`default_nettype none
`include "eis_defs.svh"
module eis_bank_monitor (
  input wire logic                 core_clk,
  input wire logic                 nrst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  input wire eis_pkg::eis_events_t ev,
  input wire logic                 rx_halt,
  input wire logic                 module_on,
  input wire logic                 packet_pending_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic acc, wr_ctrl, rd_stat, rd_irq;
  assign acc = psel & penable;
  assign wr_ctrl = acc & pwrite & (paddr == `EIS_OFF_CTRL);
  assign rd_stat = acc & !pwrite & (paddr == `EIS_OFF_STAT);
  assign rd_irq = acc & !pwrite & (paddr == `EIS_OFF_IRQ);
  property p_rxst_clr;
    acc && pwrite && paddr == `EIS_OFF_RXST |=> !rx_halt && !packet_pending_irq;
  endproperty
  a_rxst_clr: assert property (p_rxst_clr) else $error("counter not cleared");
  property p_dec_unhalt;
    rx_halt && wr_ctrl && pwdata[0] && !ev.rx_packet_ok |=> !rx_halt;
  endproperty
  a_dec_unhalt: assert property (p_dec_unhalt) else $error("halt kept");
  property p_inc_dec;
    rx_halt && wr_ctrl && pwdata[1:0] == 2'b11 && ev.rx_packet_ok && ev.rx_desc_used != 0
      |=> rx_halt;
  endproperty
  a_inc_dec: assert property (p_inc_dec) else $error("counter moved");
  property p_on_busy;
    rd_stat && $past(module_on) |-> prdata[7];
  endproperty
  a_on_busy: assert property (p_on_busy) else $error("busy low while on");
  property p_off_idle;
    rd_stat && !$past(module_on) |-> prdata[6:5] == 2'b00;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy while off");
  property p_pend_bit;
    rd_irq && $past(packet_pending_irq) |-> prdata[6];
  endproperty
  a_pend_bit: assert property (p_pend_bit) else $error("pending bit low");
  property p_irq_rise;
    $rose(packet_pending_irq) |-> $past(ev.rx_packet_ok) || $past(acc && pwrite);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("stray request");
  property p_on_write;
    wr_ctrl |=> module_on == $past(pwdata[15]);
  endproperty
  a_on_write: assert property (p_on_write) else $error("enable not taken");
  cover property (rx_halt);
  cover property (rd_stat && prdata[7]);
  cover property ($rose(packet_pending_irq));
endmodule : eis_bank_monitor
bind eis_bank eis_bank_monitor mon_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .ev(ev), .rx_halt(rx_halt), .module_on(module_on),
  .packet_pending_irq(packet_pending_irq));
`default_nettype wire

// ### testbench/eis_bank_tb.sv
// Self-checking bench for the event/status bank
`timescale 1ns/10ps
`default_nettype none
`include "eis_defs.svh"
module eis_bank_tb;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, err, rx_halt, module_on, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] cnt, u;
  eis_pkg::eis_events_t ev, lvl, e;
  int bad_count, checks_done, seed, i, k;
  eis_bank dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ev(ev), .rx_halt(rx_halt), .module_on(module_on),
    .packet_pending_irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Events in x land on the same edge as the transfer itself
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input eis_pkg::eis_events_t x);
    int n;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge core_clk);
    penable <= 1'b1;
    ev <= x | lvl;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      bad_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    ev <= lvl;
  endtask : apb
  function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] n, input logic d);
    if (n != 0 && d) return c;
    if (n != 0) return (9'(c) + 9'(n) > 9'h0ff) ? 8'hff : c + n;
    if (d && c != 0) return c - 8'h01;
    return c;
  endfunction : nxt
  // One control write carrying dec/flow bits, with a received packet using n descriptors
  task automatic step(input logic [31:0] d, input logic [7:0] n);
    e = '0;
    e.rx_packet_ok = 1'b1;
    e.rx_desc_used = n;
    apb(1'b1, `EIS_OFF_CTRL, d, 4'hf, e);
    cnt = nxt(cnt, n, d[0]);
    @(negedge core_clk);
  endtask : step
  initial begin
    #(100 * 20000);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    seed = 25642;
    {nrst, psel, penable, pwrite, paddr, pwdata, pstrb, ev, lvl, cnt} = '0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 12'(k * 16), '0, 4'hf, '0);
      chk(rd, 32'h0);
    end
    for (k = 0; k < 5; k++) begin
      i = (k == 0) ? 5 : 4 - k;
      e = eis_pkg::eis_events_t'(19'h40000 >> k);
      apb(1'b1, `EIS_OFF_IRQ + `EIS_ALIAS_CLR, ~(32'h1 << i), 4'hf, e);
      apb(1'b0, `EIS_OFF_IRQ, '0, 4'hf, '0);
      chk(rd, 32'h1 << i);
      apb(1'b1, `EIS_OFF_IRQ + `EIS_ALIAS_CLR, 32'h1 << i, 4'hf, '0);
      apb(1'b0, `EIS_OFF_IRQ, '0, 4'hf, '0);
      chk(rd, 32'h0);
    end
    apb(1'b1, `EIS_OFF_IRQ + `EIS_ALIAS_SET, 32'h40, 4'hf, '0);
    apb(1'b0, `EIS_OFF_IRQ, '0, 4'hf, '0);
    chk(rd, 32'h0);
    for (k = 0; k < 20; k++) begin
      u = 8'($random(seed)) & 8'h07;
      step(32'($random(seed)) & 32'h1, u);
    end
    apb(1'b0, `EIS_OFF_STAT, '0, 4'hf, '0);
    chk(rd[23:16], cnt);
    step(32'h2, 8'hff);
    chk(rx_halt, 1'b1);
    step(32'h3, 8'h01);
    chk(rx_halt, 1'b1);
    step(32'h3, 8'h00);
    chk(rx_halt, 1'b0);
    step(32'h0, 8'hff);
    chk(rx_halt, 1'b0);
    apb(1'b1, `EIS_OFF_IEN, 32'h40, 4'hf, '0);
    @(negedge core_clk);
    chk(irq, 1'b1);
    apb(1'b1, `EIS_OFF_RXST, 32'h0, 4'hf, '0);
    cnt = 8'h00;
    step(32'h1, 8'h00);
    chk(irq, 1'b0);
    lvl.rx_active = 1'b1;
    lvl.tx_active = 1'b1;
    lvl.txn_pending = 1'b1;
    step(32'h8000, 8'h03);
    apb(1'b0, `EIS_OFF_STAT, '0, 4'hf, '0);
    chk(rd, {8'h00, cnt, 16'h00e0});
    step(32'h0, 8'h00);
    apb(1'b0, `EIS_OFF_STAT, '0, 4'hf, '0);
    chk(rd, {8'h00, cnt, 16'h0080});
    lvl = '0;
    step(32'h1, 8'h00);
    apb(1'b0, `EIS_OFF_STAT, '0, 4'hf, '0);
    chk(rd, {8'h00, cnt, 16'h0000});
    k = 1 + (32'($random(seed)) & 32'h7);
    e = '0;
    e.rx_dropped_frame = 1'b1;
    e.tx_frame_ok = 1'b1;
    // Keep the pending enable on so the request is live while the flag word is read
    for (i = 0; i < k; i++) apb(1'b1, `EIS_OFF_IEN, 32'h40, 4'hf, e);
    apb(1'b0, `EIS_OFF_IRQ, '0, 4'hf, '0);
    chk(rd, 32'h41);
    for (i = 0; i < 2; i++) begin
      apb(1'b0, 12'(32 + 16 * i), '0, 4'hc, '0);
      chk(rd, 32'(k));
      apb(1'b0, 12'(32 + 16 * i), '0, 4'h3, '0);
      chk(rd, 32'(k));
      apb(1'b0, 12'(32 + 16 * i), '0, 4'hf, '0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h070, '0, 4'hf, '0);
    chk(err, 1'b1);
    $display("all scenarios done");
    tally_and_finish();
  end
endmodule : eis_bank_tb
`default_nettype wire
